/* bench/scrc_host_model.sv */
// Host model of the 4-wire serial port that programs the register slice.
// Assumes mclk is the slice clock; every pin moves 1 ns after a rising edge.
`timescale 1ns/1ps

module scrc_host_model (
  input  wire logic mclk,
  output logic      csb_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  // ----------------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------------
  initial begin
    csb_n = 1'b1;
    sck   = 1'b0;
    sdi   = 1'b1;
  end

  task automatic hold(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : hold

  // Sends read bit, address and data MSB first; fewer bits cut the frame.
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] d, input int bits,
                      output logic [15:0] q);
    logic [23:0] frame;
    frame = {rw, a, d};
    q     = 16'h0000;
    csb_n = 1'b0;
    for (int i = 0; i < bits; i++) begin
      sdi = frame[23-i];
      sck = 1'b0;
      hold(3);
      if (i >= 8) q = {q[14:0], sdo};
      sck = 1'b1;
      hold(3);
    end
    sck = 1'b0;
    hold(3);
    csb_n = 1'b1;
    sdi   = ~sdi;
    hold(4);
  endtask : xfer

endmodule : scrc_host_model

/* bench/testbench.sv */
// Self-checking bench for the calibration and reference register slice.
// Assumes the host model drives the serial port; the reference runs at mclk/4.
`timescale 1ns/1ps

module testbench;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic        mclk           = 1'b0;
  logic        rst_n          = 1'b0;
  logic        referenceInput = 1'b0;
  logic        ampCmpStart    = 1'b0;
  logic [8:0]  ampCalValue    = 9'h0AA;
  logic [8:0]  ampDacValue    = 9'h12C;
  logic [7:0]  capCalCode     = 8'h55;
  logic [7:0]  capbankCode    = 8'hC3;
  logic        coreForce      = 1'b0;
  logic [2:0]  coreSelect     = 3'h5;
  logic [2:0]  coreCalSelect  = 3'h2;
  logic [1:0]  refPhase       = 2'h0;
  logic        csb_n, sck, sdi, sdo, swResetPulse, powerDown, calTick, ampCmpDone;
  logic        ampCalRun, freqCalRun, refDoublerEnable, refPathEnable;
  logic [8:0]  ampSetting;
  logic [7:0]  capSetting;
  logic [2:0]  coreSel;
  logic [4:0]  inputMultiplierValue;
  logic [4:0]  flags;
  logic [15:0] rd;
  int          badCount = 0;
  int          totalChecks = 0;
  int          tickCnt = 0;
  int          pulseCnt = 0;
  int          n, t0;
  logic [6:0]  addrTab [8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h07, 7'h08, 7'h09, 7'h0A};
  logic [15:0] rstTab [8] = '{16'h201C, 16'h0003, 16'h0000, 16'h1900, 16'h0000, 16'h0000, 16'h0200, 16'h0080};
  logic [15:0] cfgTab [8] = '{16'h201C, 16'h0000, 16'hA5A5, 16'h0700, 16'h5A5A, 16'h2400, 16'h0200, 16'h0600};

  assign flags = {powerDown, ampCalRun, freqCalRun, refDoublerEnable, refPathEnable};

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    refPhase <= refPhase + 2'h1;
    referenceInput <= #1 refPhase[1];
    if (calTick === 1'b1) tickCnt <= tickCnt + 1;
    if (swResetPulse === 1'b1) pulseCnt <= pulseCnt + 1;
  end

  scrc_host_model host_u (.mclk, .csb_n, .sck, .sdi, .sdo);

  scrc_config_regs dut_u (.mclk, .rst_n, .csb_n, .sck, .sdi, .sdo, .referenceInput, .ampCmpStart, .ampCalValue,
    .ampDacValue, .capCalCode, .capbankCode, .coreForce, .coreSelect, .coreCalSelect, .swResetPulse, .powerDown,
    .calTick, .ampCmpDone, .ampCalRun, .freqCalRun, .ampSetting, .capSetting, .coreSel, .refDoublerEnable,
    .refPathEnable, .inputMultiplierValue);

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host_u.xfer(1'b0, a, d, 24, rd);
  endtask : wr

  task automatic rdAll(input logic [15:0] exp [8]);
    for (int i = 0; i < 8; i++) begin
      host_u.xfer(1'b1, addrTab[i], 16'h0000, 24, rd);
      chk($sformatf("register %h", addrTab[i]), exp[i], rd);
    end
  endtask : rdAll

  task automatic waitHigh(input bit selDone, output int k);
    for (k = 1; k <= 400; k++) begin
      cyc(1);
      if ((selDone ? ampCmpDone : calTick) === 1'b1) return;
    end
    $display("unexpected wait: expected pulse, seen none");
    badCount++;
    testDone();
  endtask : waitHigh

  task automatic testDone();
    $display("checks %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : testDone

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    cyc(12);
    rst_n = 1'b1;
    cyc(1);
    rdAll(rstTab);
    chk("flags", 16'h000D, 16'(flags));
    for (int d = 3; d >= 0; d--) begin
      wr(7'h01, 16'(d));
      waitHigh(1'b0, n);
      waitHigh(1'b0, n);
      waitHigh(1'b0, n);
      chk("tick interval", 16'(4 << d), 16'(n));
    end
    wr(7'h04, 16'h0700);
    waitHigh(1'b0, n);
    ampCmpStart = 1'b1;
    cyc(1);
    ampCmpStart = 1'b0;
    t0 = tickCnt;
    waitHigh(1'b1, n);
    chk("compare ticks", 16'h000E, 16'(tickCnt - t0));
    wr(7'h09, 16'h0800);
    chk("flags", 16'h000E, 16'(flags));
    t0 = tickCnt;
    cyc(100);
    chk("ticks", 16'h0000, 16'(tickCnt - t0));
    wr(7'h09, 16'h0200);
    wr(7'h00, 16'h201D);
    chk("flags", 16'h001D, 16'(flags));
    t0 = tickCnt;
    cyc(100);
    chk("ticks", 16'h0000, 16'(tickCnt - t0));
    wr(7'h00, 16'h201C);
    wr(7'h0A, 16'h0600);
    chk("multiplier", 16'h000C, 16'(inputMultiplierValue));
    chk("amp setting", 16'(ampCalValue), 16'(ampSetting));
    chk("cap setting", 16'(capCalCode), 16'(capSetting));
    chk("core", 16'(coreCalSelect), 16'(coreSel));
    wr(7'h08, 16'h2400);
    chk("amp setting", 16'h012C, 16'(ampSetting));
    chk("cap setting", 16'h00C3, 16'(capSetting));
    chk("flags", 16'h0001, 16'(flags));
    coreForce = 1'b1;
    for (int c = 1; c <= 7; c++) begin
      coreSelect = 3'(c);
      cyc(2);
      chk("core", 16'(c), 16'(coreSel));
    end
    wr(7'h02, 16'hA5A5);
    wr(7'h07, 16'h5A5A);
    host_u.xfer(1'b0, 7'h09, 16'h0000, 23, rd);
    wr(7'h03, 16'hFFFF);
    host_u.xfer(1'b1, 7'h03, 16'h0000, 24, rd);
    chk("unmapped", 16'h0000, rd);
    rdAll(cfgTab);
    t0 = pulseCnt;
    wr(7'h00, 16'h201E);
    chk("reset pulses", 16'h0001, 16'(pulseCnt - t0));
    rdAll(rstTab);
    chk("flags", 16'h000D, 16'(flags));
    chk("amp setting", 16'(ampCalValue), 16'(ampSetting));
    testDone();
  end

endmodule : testbench

/* src/scrc_config_regs.sv */
// Register slice of a serially programmed synthesizer: serial port, reset,
// power-down, calibration clock divider, comparison delay, override muxes.
// Assumes all pins are synchronous to mclk and sck is far slower than mclk.
//
// What this block does
// - Writing reset bit resets device, bit self-clears.
// - Bit zero drives powerDown and stops calibration ticks.
// - Calibration clock is reference over two to divider.
// - Comparison delay field resets to 25, counts twice that many ticks.
// - Amplitude override uses programmed amplitude value.
// - Capacitor override skips frequency calibration, uses code.
// - Manual core chosen by force bit under capacitor override, core 1-7.
// - Bit eleven enables reference doubler, resets zero.
// - Bit nine enables reference path, resets one.
// - Frame is read bit, 7-bit address, 16 data.
`timescale 1ns/1ps

module scrc_config_regs #(
  parameter int unsigned AMP_W = 9,
  parameter int unsigned CAP_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             csb_n,
  input  wire logic             sck,
  input  wire logic             sdi,
  output logic                  sdo,
  input  wire logic             referenceInput,
  input  wire logic             ampCmpStart,
  input  wire logic [AMP_W-1:0] ampCalValue,
  input  wire logic [AMP_W-1:0] ampDacValue,
  input  wire logic [CAP_W-1:0] capCalCode,
  input  wire logic [CAP_W-1:0] capbankCode,
  input  wire logic             coreForce,
  input  wire logic [2:0]       coreSelect,
  input  wire logic [2:0]       coreCalSelect,
  output logic                  swResetPulse,
  output logic                  powerDown,
  output logic                  calTick,
  output logic                  ampCmpDone,
  output logic                  ampCalRun,
  output logic                  freqCalRun,
  output logic [AMP_W-1:0]      ampSetting,
  output logic [CAP_W-1:0]      capSetting,
  output logic [2:0]            coreSel,
  output logic                  refDoublerEnable,
  output logic                  refPathEnable,
  output logic [4:0]            inputMultiplierValue
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // Address decode and readback
  // ----------------------------------------------------------------------
  function automatic logic [3:0] addrDecode(input logic [6:0] addr);
    unique case (addr)
      scrc_pkg::OFS_TOP_CONTROL:   addrDecode = {1'b1, scrc_pkg::IDX_TOP_CONTROL};
      scrc_pkg::OFS_CAL_CLK_DIV:   addrDecode = {1'b1, scrc_pkg::IDX_CAL_CLK_DIV};
      scrc_pkg::OFS_RESERVED_TWO:  addrDecode = {1'b1, scrc_pkg::IDX_RESERVED_TWO};
      scrc_pkg::OFS_AMP_CAL_DELAY: addrDecode = {1'b1, scrc_pkg::IDX_AMP_CAL_DELAY};
      scrc_pkg::OFS_RESERVED_SVN:  addrDecode = {1'b1, scrc_pkg::IDX_RESERVED_SVN};
      scrc_pkg::OFS_OSC_OVERRIDE:  addrDecode = {1'b1, scrc_pkg::IDX_OSC_OVERRIDE};
      scrc_pkg::OFS_REF_PATH_CFG:  addrDecode = {1'b1, scrc_pkg::IDX_REF_PATH_CFG};
      scrc_pkg::OFS_INPUT_INPUT_MULTIPLIER_VALUE:    addrDecode = {1'b1, scrc_pkg::IDX_INPUT_INPUT_MULTIPLIER_VALUE};
      default:                     addrDecode = 4'h0;
    endcase
  endfunction : addrDecode

  // ----------------------------------------------------------------------
  // Serial port state
  // ----------------------------------------------------------------------
  scrc_pkg::scrc_frame_e            state_r, state_nxt;
  logic [4:0]                       bitCnt_r, bitCnt_nxt;
  logic [scrc_pkg::FRAME_BITS-1:0]  shift_r, shift_nxt;
  logic [15:0]                      rdData_r, rdData_nxt;
  logic                             sdo_r, sdo_nxt, isRead_r, isRead_nxt;
  logic                             sckPrev_r, csbPrev_r;
  logic [scrc_pkg::NUM_REGS-1:0][15:0] regs_r, regs_nxt;
  logic                             swReset_r, swReset_nxt;
  logic                             sckRise, sckFall, csbRise, commit;
  logic [3:0]                       wrDec, rdDec;

  assign sckRise = !csb_n && sck && !sckPrev_r;
  assign sckFall = !csb_n && !sck && sckPrev_r;
  assign csbRise = csb_n && !csbPrev_r;
  assign wrDec   = addrDecode(shift_r[22:16]);
  assign rdDec   = addrDecode(shift_nxt[6:0]);
  assign commit  = (state_r == scrc_pkg::ST_SHIFT) && csbRise
                   && (bitCnt_r == 5'(scrc_pkg::FRAME_BITS)) && !shift_r[23];

  always_comb begin
    state_nxt  = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt  = shift_r;
    rdData_nxt = rdData_r;
    sdo_nxt    = sdo_r;
    isRead_nxt = isRead_r;
    unique case (state_r)
      scrc_pkg::ST_IDLE: begin
        sdo_nxt = 1'b0;
        isRead_nxt = 1'b0;
        if (!csb_n) begin
          state_nxt  = scrc_pkg::ST_SHIFT;
          bitCnt_nxt = 5'h00;
        end
      end
      scrc_pkg::ST_SHIFT: begin
        if (csb_n) begin
          state_nxt = scrc_pkg::ST_IDLE;
          sdo_nxt   = 1'b0;
        end else if (sckRise) begin
          shift_nxt = {shift_r[scrc_pkg::FRAME_BITS-2:0], sdi};
          if (bitCnt_r != 5'h1F) begin
            bitCnt_nxt = bitCnt_r + 5'h01;
          end
          if (bitCnt_r == 5'(scrc_pkg::HDR_BITS - 1)) begin
            rdData_nxt = rdDec[3] ? regs_r[rdDec[2:0]] : 16'h0000;
            isRead_nxt = shift_r[6];
          end
        end else if (sckFall && isRead_r && bitCnt_r >= 5'(scrc_pkg::HDR_BITS)
                     && bitCnt_r < 5'(scrc_pkg::FRAME_BITS)) begin
          sdo_nxt    = rdData_r[15];
          rdData_nxt = {rdData_r[14:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= scrc_pkg::ST_IDLE;
      bitCnt_r  <= 5'h00;
      shift_r   <= 24'h000000;
      rdData_r  <= 16'h0000;
      sdo_r     <= 1'b0;
      isRead_r  <= 1'b0;
      sckPrev_r <= 1'b0;
      csbPrev_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      bitCnt_r  <= bitCnt_nxt;
      shift_r   <= shift_nxt;
      rdData_r  <= rdData_nxt;
      sdo_r     <= sdo_nxt;
      isRead_r  <= isRead_nxt;
      sckPrev_r <= sck;
      csbPrev_r <= csb_n;
    end
  end

  // ----------------------------------------------------------------------
  // Register file and software reset
  // ----------------------------------------------------------------------
  always_comb begin
    regs_nxt    = regs_r;
    swReset_nxt = 1'b0;
    if (commit && wrDec[3]) begin
      if (wrDec[2:0] == scrc_pkg::IDX_TOP_CONTROL && shift_r[scrc_pkg::TOP_SOFT_RESET]) begin
        regs_nxt    = scrc_pkg::RST_VALS;
        swReset_nxt = 1'b1;
      end else begin
        regs_nxt[wrDec[2:0]] = shift_r[15:0];
        regs_nxt[scrc_pkg::IDX_TOP_CONTROL][scrc_pkg::TOP_SOFT_RESET] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r    <= scrc_pkg::RST_VALS;
      swReset_r <= 1'b0;
    end else begin
      regs_r    <= regs_nxt;
      swReset_r <= swReset_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration clock, comparison delay and override muxes
  // ----------------------------------------------------------------------
  logic [6:0]       calCnt_r, calCnt_nxt;
  logic             calTick_r, calTick_nxt, refPrev_r;
  logic [8:0]       cmpCnt_r, cmpCnt_nxt;
  logic             cmpBusy_r, cmpBusy_nxt, cmpDone_r, cmpDone_nxt;
  logic             pwrDn_r, dbl_r, refEn_r, ampRun_r, freqRun_r;
  logic [AMP_W-1:0] amp_r, amp_nxt;
  logic [CAP_W-1:0] cap_r, cap_nxt;
  logic [2:0]       core_r, core_nxt;
  logic [4:0]       input_multiplier_value_r;
  logic [2:0]       calDiv;
  logic [7:0]       calPeriod;
  logic             refRise, ampOvr, capOvr, calRestart;

  assign calDiv    = regs_r[scrc_pkg::IDX_CAL_CLK_DIV][scrc_pkg::CAL_DIV_LSB +: scrc_pkg::CAL_DIV_W];
  assign calPeriod = 8'h01 << calDiv;
  assign refRise   = referenceInput && !refPrev_r && refEn_r && !pwrDn_r;
  assign ampOvr    = regs_r[scrc_pkg::IDX_OSC_OVERRIDE][scrc_pkg::OVR_AMP_BIT];
  assign capOvr    = regs_r[scrc_pkg::IDX_OSC_OVERRIDE][scrc_pkg::OVR_CAP_BIT];
  assign calRestart = commit && wrDec == {1'b1, scrc_pkg::IDX_CAL_CLK_DIV};

  always_comb begin
    calCnt_nxt  = calCnt_r;
    calTick_nxt = 1'b0;
    cmpCnt_nxt  = cmpCnt_r;
    cmpBusy_nxt = cmpBusy_r;
    cmpDone_nxt = 1'b0;
    if (refRise) begin
      if ({1'b0, calCnt_r} == calPeriod - 8'h01) begin
        calCnt_nxt  = 7'h00;
        calTick_nxt = 1'b1;
      end else begin
        calCnt_nxt = calCnt_r + 7'h01;
      end
    end
    if (ampCmpStart && !cmpBusy_r) begin
      cmpBusy_nxt = 1'b1;
      cmpCnt_nxt  = {regs_r[scrc_pkg::IDX_AMP_CAL_DELAY][scrc_pkg::AMP_DLY_LSB +: scrc_pkg::AMP_DLY_W], 1'b0};
    end else if (cmpBusy_r && calTick_r) begin
      if (cmpCnt_r <= 9'h001) begin
        cmpBusy_nxt = 1'b0;
        cmpDone_nxt = 1'b1;
        cmpCnt_nxt  = 9'h000;
      end else begin
        cmpCnt_nxt = cmpCnt_r - 9'h001;
      end
    end
    if (swReset_r) begin
      calCnt_nxt  = 7'h00;
      cmpBusy_nxt = 1'b0;
      cmpCnt_nxt  = 9'h000;
    end
    if (calRestart) begin
      calCnt_nxt = 7'h00;
    end
    amp_nxt  = ampOvr ? ampDacValue : ampCalValue;
    cap_nxt  = capOvr ? capbankCode : capCalCode;
    core_nxt = (capOvr && coreForce && coreSelect != 3'h0) ? coreSelect : coreCalSelect;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      calCnt_r  <= 7'h00;
      calTick_r <= 1'b0;
      refPrev_r <= 1'b0;
      cmpCnt_r  <= 9'h000;
      cmpBusy_r <= 1'b0;
      cmpDone_r <= 1'b0;
      pwrDn_r   <= 1'b0;
      dbl_r     <= 1'b0;
      refEn_r   <= 1'b1;
      ampRun_r  <= 1'b1;
      freqRun_r <= 1'b1;
      amp_r     <= '0;
      cap_r     <= '0;
      core_r    <= 3'h0;
      input_multiplier_value_r    <= 5'h01;
    end else begin
      calCnt_r  <= calCnt_nxt;
      calTick_r <= calTick_nxt;
      refPrev_r <= referenceInput;
      cmpCnt_r  <= cmpCnt_nxt;
      cmpBusy_r <= cmpBusy_nxt;
      cmpDone_r <= cmpDone_nxt;
      pwrDn_r   <= regs_r[scrc_pkg::IDX_TOP_CONTROL][scrc_pkg::TOP_POWER_DOWN];
      dbl_r     <= regs_r[scrc_pkg::IDX_REF_PATH_CFG][scrc_pkg::REF_DOUBLER_BIT];
      refEn_r   <= regs_r[scrc_pkg::IDX_REF_PATH_CFG][scrc_pkg::REF_ENABLE_BIT];
      ampRun_r  <= regs_r[scrc_pkg::IDX_TOP_CONTROL][scrc_pkg::TOP_AMP_CAL_EN] && !ampOvr;
      freqRun_r <= regs_r[scrc_pkg::IDX_TOP_CONTROL][scrc_pkg::TOP_FREQ_CAL_EN] && !capOvr;
      amp_r     <= amp_nxt;
      cap_r     <= cap_nxt;
      core_r    <= core_nxt;
      input_multiplier_value_r    <= regs_r[scrc_pkg::IDX_INPUT_INPUT_MULTIPLIER_VALUE][scrc_pkg::INPUT_MULTIPLIER_VALUE_LSB +: scrc_pkg::INPUT_MULTIPLIER_VALUE_W];
    end
  end

  assign sdo                  = sdo_r;
  assign swResetPulse         = swReset_r;
  assign powerDown            = pwrDn_r;
  assign calTick              = calTick_r;
  assign ampCmpDone           = cmpDone_r;
  assign ampCalRun            = ampRun_r;
  assign freqCalRun           = freqRun_r;
  assign ampSetting           = amp_r;
  assign capSetting           = cap_r;
  assign coreSel              = core_r;
  assign refDoublerEnable     = dbl_r;
  assign refPathEnable        = refEn_r;
  assign inputMultiplierValue = input_multiplier_value_r;

  // ----------------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------------
  logic [7:0] refSinceTick_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refSinceTick_r <= 8'h00;
    end else if (calTick_nxt || swReset_r || calRestart) begin
      refSinceTick_r <= 8'h00;
    end else if (refRise) begin
      refSinceTick_r <= refSinceTick_r + 8'h01;
    end
  end

  a_swrst_one_pulse: assert property (commit && wrDec == {1'b1, scrc_pkg::IDX_TOP_CONTROL}
    && shift_r[scrc_pkg::TOP_SOFT_RESET] |=> swReset_r ##1 !swReset_r)
    else $error("soft reset pulse not one cycle");
  a_swrst_restores: assert property (swReset_r |-> regs_r == scrc_pkg::RST_VALS)
    else $error("soft reset did not restore registers");
  a_rst_bit_clear: assert property (!regs_r[scrc_pkg::IDX_TOP_CONTROL][scrc_pkg::TOP_SOFT_RESET])
    else $error("reset bit did not self-clear");
  a_pwrdn_stops_ticks: assert property (pwrDn_r || !refEn_r |=> !calTick_r)
    else $error("calibration tick while powered down");
  a_caldiv_period: assert property (calTick_nxt && !swReset_r |-> refSinceTick_r == calPeriod - 8'h01)
    else $error("calibration tick spacing wrong");
  a_cmp_delay_done: assert property (cmpDone_r |-> $past(cmpBusy_r) && $past(calTick_r) && !cmpBusy_r)
    else $error("comparison delay ended without tick");
  a_amp_override: assert property ($past(ampOvr) |-> amp_r == $past(ampDacValue) && !ampRun_r)
    else $error("amplitude override not applied");
  a_cap_override: assert property ($past(capOvr) |-> cap_r == $past(capbankCode) && !freqRun_r)
    else $error("capacitor override not applied");
  a_core_force: assert property ($past(capOvr && coreForce && coreSelect != 3'h0) |-> core_r == $past(coreSelect))
    else $error("forced core not selected");
  a_ref_bits: assert property (##1 dbl_r == $past(regs_r[6][scrc_pkg::REF_DOUBLER_BIT])
    && refEn_r == $past(regs_r[6][scrc_pkg::REF_ENABLE_BIT])) else $error("reference bits not followed");
  a_frame_length: assert property (commit |-> $past(bitCnt_r) == 5'h18 && state_nxt == scrc_pkg::ST_IDLE)
    else $error("write committed with wrong frame length");

  c_write_frame: cover property (commit && wrDec[3]);
  c_read_frame: cover property (sckFall && isRead_r && bitCnt_r == 5'h17);
  c_soft_reset: cover property (swReset_r);
  c_cmp_done: cover property (cmpDone_r);

endmodule : scrc_config_regs

/* src/scrc_pkg.sv */
// Constants of the calibration and reference configuration register slice.
// Assumes a 4-wire serial port: 24-bit frames, MSB first, sampled on mclk.
package scrc_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned HDR_BITS   = 8;
  localparam int unsigned DATA_BITS  = 16;
  localparam int unsigned ADDR_BITS  = 7;
  localparam int unsigned NUM_REGS   = 8;
  localparam int unsigned IDX_BITS   = 3;

  // ----------------------------------------------------------------------
  // Register offsets and storage indices
  // ----------------------------------------------------------------------
  localparam logic [6:0] OFS_TOP_CONTROL   = 7'h00;
  localparam logic [6:0] OFS_CAL_CLK_DIV   = 7'h01;
  localparam logic [6:0] OFS_RESERVED_TWO  = 7'h02;
  localparam logic [6:0] OFS_AMP_CAL_DELAY = 7'h04;
  localparam logic [6:0] OFS_RESERVED_SVN  = 7'h07;
  localparam logic [6:0] OFS_OSC_OVERRIDE  = 7'h08;
  localparam logic [6:0] OFS_REF_PATH_CFG  = 7'h09;
  localparam logic [6:0] OFS_INPUT_INPUT_MULTIPLIER_VALUE    = 7'h0A;

  localparam logic [2:0] IDX_TOP_CONTROL   = 3'h0;
  localparam logic [2:0] IDX_CAL_CLK_DIV   = 3'h1;
  localparam logic [2:0] IDX_RESERVED_TWO  = 3'h2;
  localparam logic [2:0] IDX_AMP_CAL_DELAY = 3'h3;
  localparam logic [2:0] IDX_RESERVED_SVN  = 3'h4;
  localparam logic [2:0] IDX_OSC_OVERRIDE  = 3'h5;
  localparam logic [2:0] IDX_REF_PATH_CFG  = 3'h6;
  localparam logic [2:0] IDX_INPUT_INPUT_MULTIPLIER_VALUE    = 3'h7;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned TOP_POWER_DOWN   = 0;
  localparam int unsigned TOP_SOFT_RESET   = 1;
  localparam int unsigned TOP_FREQ_CAL_EN  = 3;
  localparam int unsigned TOP_AMP_CAL_EN   = 4;
  localparam int unsigned CAL_DIV_LSB      = 0;
  localparam int unsigned CAL_DIV_W        = 3;
  localparam int unsigned AMP_DLY_LSB      = 8;
  localparam int unsigned AMP_DLY_W        = 8;
  localparam int unsigned OVR_AMP_BIT      = 13;
  localparam int unsigned OVR_CAP_BIT      = 10;
  localparam int unsigned REF_DOUBLER_BIT  = 11;
  localparam int unsigned REF_ENABLE_BIT   = 9;
  localparam int unsigned INPUT_MULTIPLIER_VALUE_LSB         = 7;
  localparam int unsigned INPUT_MULTIPLIER_VALUE_W           = 5;

  // ----------------------------------------------------------------------
  // Reset values, ordered by storage index
  // ----------------------------------------------------------------------
  localparam logic [NUM_REGS-1:0][15:0] RST_VALS = {
    16'h0080, 16'h0200, 16'h0000, 16'h0000, 16'h1900, 16'h0000, 16'h0003, 16'h201C
  };

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } scrc_frame_e;

endpackage : scrc_pkg
